//--- logic/bmu_defs.svh
// byte multiplier unit: addresses, field positions, reset values and timing counts
`ifndef BMU_DEFS_SVH
`define BMU_DEFS_SVH

`define BMU_ADDR_CTRL 16'hffd2
`define BMU_ADDR_RES_LO 16'hffd0
`define BMU_ADDR_RES_HI 16'hffd1
`define BMU_ADDR_OPA 16'hffd4
`define BMU_ADDR_OPB 16'hffd5

`define BMU_RUN_BIT 3'h0
`define BMU_CTRL_RESET 1'h0

`define BMU_CNT_W 3
`define BMU_CNT_LAST 3'h7
`define BMU_STEP_DIV 2
`define BMU_PRODUCT_CYCLES 16

`endif

//--- logic/bmu_pkg.sv
// byte multiplier unit: shared types
package bmu_pkg;

    // access width of a processor transfer; codes 0, 1 and 3, so word sits two steps from byte
    typedef enum logic [1:0] {
        BMU_ACC_BIT = 2'h0,
        BMU_ACC_BYTE = 2'h1,
        BMU_ACC_WORD = 2'h3
    } bmu_acc_t;

endpackage

//--- logic/bmu_core_if.sv
// byte multiplier unit: link between register front end and shift-add engine
`timescale 1ns/100ps
interface bmu_core_if;
    logic run;
    logic [7:0] op_a;
    logic [7:0] op_b;
    logic [2:0] count;
    logic step;
    logic [15:0] slave;
    logic [15:0] product;

    modport regs (
        output run,
        output op_a,
        output op_b,
        input count,
        input step,
        input slave,
        input product
    );

    modport engine (
        input run,
        input op_a,
        input op_b,
        output count,
        output step,
        output slave,
        output product
    );
endinterface

//--- logic/bmu_engine.sv
// byte multiplier unit: shift-and-add engine with cycle counter and slave accumulator
`timescale 1ns/100ps
`include "bmu_defs.svh"
module bmu_engine import bmu_pkg::*; (
    input wire logic mclk,
    input wire logic rst_b,
    bmu_core_if.engine core
);

    logic div_reg;
    logic [2:0] count_reg;
    logic [15:0] slave_reg;
    logic [15:0] product_reg;
    logic [15:0] select_out;
    logic [15:0] sum_next;

    // one accumulate step per two mclk, so eight steps span sixteen cycles
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_reg <= 1'b0;
        end else if (!core.run) begin
            div_reg <= 1'b0;
        end else begin
            div_reg <= ~div_reg;
        end
    end

    assign core.step = core.run & div_reg;

    always_comb begin
        if (core.op_b[count_reg]) begin
            select_out = {8'h00, core.op_a} << count_reg;
        end else begin
            select_out = 16'h0000;
        end
        // the product never exceeds 16 bits, so the carry out is dropped on purpose
        sum_next = 16'(slave_reg + select_out);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= 3'h0;
        end else if (!core.run) begin
            count_reg <= 3'h0;
        end else if (core.step) begin
            count_reg <= count_reg + 3'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            slave_reg <= 16'h0000;
        end else if (!core.run) begin
            slave_reg <= 16'h0000;
        end else if (core.step) begin
            slave_reg <= sum_next;
        end
    end

    // no reset on purpose: the result is undefined until a product is formed
    always_ff @(posedge mclk) begin
        if (core.step) begin
            product_reg <= sum_next;
        end
    end

    assign core.count = count_reg;
    assign core.slave = slave_reg;
    assign core.product = product_reg;

endmodule // bmu_engine

//--- logic/bmu_top.sv
// byte multiplier unit: processor register front end, engine instance and checks
//
// Contract
// - product readable in a 16-bit result register
// - full product present 16 CPU clocks after start
// - reset leaves result register undefined
// - result reachable by 16-bit and 8-bit accesses
// - multiply the two 8-bit operand registers
// - operands take bit and byte writes, no reset
// - control at ffd2, reset to zero, unit stopped
// - writing start bit 0 clears counter and stops
// - writing 1 starts; read bit shows running
// - control takes bit and byte writes
// - each step adds selector output, counter increments
// - clearing at count 111 stops, result kept
// - while stopped, counter and slave held cleared
`timescale 1ns/100ps
`include "bmu_defs.svh"
module bmu_top import bmu_pkg::*; (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire bmu_acc_t cpu_size,
    input wire logic [2:0] cpu_bit,
    input wire logic [7:0] cpu_wdata,
    output logic [15:0] cpu_rdata
);

    bmu_core_if core ();

    logic run_reg;
    logic [7:0] op_a_reg;
    logic [7:0] op_b_reg;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic hit_ctrl;
    logic hit_opa;
    logic hit_opb;
    logic is_bit;
    logic is_byte;
    logic wr_small;

    assign hit_ctrl = (cpu_addr == `BMU_ADDR_CTRL);
    assign hit_opa = (cpu_addr == `BMU_ADDR_OPA);
    assign hit_opb = (cpu_addr == `BMU_ADDR_OPB);
    assign is_bit = (cpu_size == BMU_ACC_BIT);
    assign is_byte = (cpu_size == BMU_ACC_BYTE);
    assign wr_small = cpu_wr & (is_bit | is_byte);

    // control: only the start bit is stored, bits 1-7 have no flops
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            run_reg <= `BMU_CTRL_RESET;
        end else if (wr_small && hit_ctrl) begin
            if (is_byte || cpu_bit == `BMU_RUN_BIT) begin
                run_reg <= cpu_wdata[0];
            end
        end
    end

    // operands have no reset; software must load them before starting
    always_ff @(posedge mclk) begin
        if (wr_small && hit_opa) begin
            if (is_byte) begin
                op_a_reg <= cpu_wdata;
            end else begin
                op_a_reg[cpu_bit] <= cpu_wdata[0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (wr_small && hit_opb) begin
            if (is_byte) begin
                op_b_reg <= cpu_wdata;
            end else begin
                op_b_reg[cpu_bit] <= cpu_wdata[0];
            end
        end
    end

    assign core.run = run_reg;
    assign core.op_a = op_a_reg;
    assign core.op_b = op_b_reg;

    bmu_engine u_engine (
        .mclk(mclk),
        .rst_b(rst_b),
        .core(core)
    );

    // read path; writes to the result and word writes anywhere are ignored
    always_comb begin
        rdata_next = 16'h0000;
        if (cpu_size == BMU_ACC_WORD) begin
            if (cpu_addr == `BMU_ADDR_RES_LO) begin
                rdata_next = core.product;
            end
        end else begin
            unique case (cpu_addr)
                `BMU_ADDR_RES_LO: begin
                    rdata_next = {8'h00, core.product[7:0]};
                end
                `BMU_ADDR_RES_HI: begin
                    rdata_next = {8'h00, core.product[15:8]};
                end
                `BMU_ADDR_OPA: begin
                    rdata_next = {8'h00, op_a_reg};
                end
                `BMU_ADDR_OPB: begin
                    rdata_next = {8'h00, op_b_reg};
                end
                `BMU_ADDR_CTRL: begin
                    rdata_next = {15'h0000, run_reg};
                end
                default: begin
                    rdata_next = 16'h0000;
                end
            endcase
            if (is_bit) begin
                rdata_next = {15'h0000, rdata_next[cpu_bit]};
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 16'h0000;
        end else if (cpu_rd) begin
            rdata_reg <= rdata_next;
        end
    end

    assign cpu_rdata = rdata_reg;

    // ---- checks ----
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    localparam int PROD_CYC = `BMU_PRODUCT_CYCLES;

    // cycles of running with operands untouched; saturates well past the product time
    logic [4:0] run_age_reg;
    logic op_write;

    assign op_write = wr_small & (hit_opa | hit_opb);

    // result holds unknowns until the first step after reset; stability checks wait for it
    logic prod_seen_reg;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prod_seen_reg <= 1'b0;
        end else if (core.step) begin
            prod_seen_reg <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            run_age_reg <= 5'h00;
        end else if (!run_reg || op_write) begin
            run_age_reg <= 5'h00;
        end else if (run_age_reg != 5'h1f) begin
            run_age_reg <= run_age_reg + 5'h01;
        end
    end

    sequence s_start;
        wr_small && hit_ctrl && is_byte && cpu_wdata[0];
    endsequence

    sequence s_stop;
        wr_small && hit_ctrl && is_byte && !cpu_wdata[0];
    endsequence

    sequence s_bit_start;
        wr_small && hit_ctrl && is_bit && (cpu_bit == 3'h0) && cpu_wdata[0];
    endsequence

    sequence s_bit_other;
        wr_small && hit_ctrl && is_bit && (cpu_bit != 3'h0);
    endsequence

    a_start_runs: assert property (s_start |=> run_reg)
        else $error("start write did not set run");

    a_stop_clears: assert property (s_stop |=> !run_reg ##1 (core.count == 3'h0))
        else $error("stop write did not clear run and counter");

    a_idle_cleared: assert property (!run_reg |=> core.count == 3'h0 && core.slave == 16'h0000)
        else $error("counter or slave not cleared while stopped");

    a_count_step: assert property (core.step |=> core.count == $past(core.count) + 3'h1)
        else $error("counter did not advance on a step");

    a_count_hold: assert property (run_reg && !core.step && run_age_reg != 5'h00
        |=> $stable(core.count))
        else $error("counter moved without a step");

    a_step_rate: assert property (core.step |=> !core.step)
        else $error("steps closer than two cycles");

    a_full_product: assert property (run_age_reg == PROD_CYC[4:0]
        |-> core.product == {8'h00, op_a_reg} * {8'h00, op_b_reg})
        else $error("product wrong sixteen cycles after start");

    a_result_kept: assert property (prod_seen_reg && !run_reg ##1 !run_reg
        |-> $stable(core.product))
        else $error("result changed while stopped");

    a_bit_start: assert property (s_bit_start |=> run_reg)
        else $error("bit write of start did not set run");

    a_bit_other: assert property (s_bit_other |=> $stable(run_reg))
        else $error("bit write to an unused control bit moved run");

    a_opa_byte: assert property (wr_small && hit_opa && is_byte
        |=> op_a_reg == $past(cpu_wdata))
        else $error("byte write of operand a lost");

    a_opb_bit: assert property (wr_small && hit_opb && is_bit
        |=> op_b_reg[$past(cpu_bit)] == $past(cpu_wdata[0]))
        else $error("bit write of operand b lost");

    a_high_read: assert property (cpu_rd && is_byte && cpu_addr == `BMU_ADDR_RES_HI
        |=> cpu_rdata == {8'h00, $past(core.product[15:8])})
        else $error("byte read of result high wrong");

    a_ctrl_read: assert property (cpu_rd && hit_ctrl && is_byte
        |=> cpu_rdata == {15'h0000, $past(run_reg)})
        else $error("control readback wrong");

    a_word_read: assert property (cpu_rd && cpu_size == BMU_ACC_WORD
        && cpu_addr == `BMU_ADDR_RES_LO |=> cpu_rdata == $past(core.product))
        else $error("word read of result wrong");

endmodule // bmu_top

//--- tb/byte_multiplier_unit_bench.sv
// bench for the byte multiplier unit: register traffic with queued expected reads
`timescale 1ns/100ps
`include "bmu_defs.svh"
module byte_multiplier_unit_bench import bmu_pkg::*; ;
    localparam logic [15:0] CTL = `BMU_ADDR_CTRL;
    localparam logic [15:0] RLO = `BMU_ADDR_RES_LO;
    localparam logic [15:0] RHI = `BMU_ADDR_RES_HI;
    localparam logic [15:0] OPA = `BMU_ADDR_OPA;
    localparam logic [15:0] OPB = `BMU_ADDR_OPB;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic cpu_wr = 1'b0;
    logic cpu_rd = 1'b0;
    bmu_acc_t cpu_size = BMU_ACC_BYTE;
    logic [2:0] cpu_bit = 3'h0;
    logic [7:0] cpu_wdata = 8'h00;
    logic [15:0] cpu_rdata;
    logic [15:0] exp_q[$];
    logic rd_d1 = 1'b0;
    logic rd_d2 = 1'b0;
    int cyc = 0;
    int n_mismatch = 0;
    int checked = 0;
    int seed = 55961;

    always #25 mclk = ~mclk;

    bmu_top i_dut (.mclk(mclk), .rst_b(rst_b), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_size(cpu_size), .cpu_bit(cpu_bit), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata));

    task automatic results();
        if (exp_q.size() != 0) begin
            n_mismatch++;
            $display("mismatch at %0t: %0d reads never answered", $time, exp_q.size());
        end
        $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic cmp_rd(input logic [15:0] got, input logic [15:0] want);
        checked++;
        if (got !== want) begin
            n_mismatch++;
            $display("mismatch at %0t: read %h, expected %h", $time, got, want);
        end
    endtask

    // called at a falling edge; strobe lasts exactly one rising edge
    task automatic acc(input logic w, input bmu_acc_t s, input logic [15:0] a,
        input logic [2:0] b, input logic [7:0] d);
        cpu_wr = w;
        cpu_rd = ~w;
        cpu_size = s;
        cpu_addr = a;
        cpu_bit = b;
        cpu_wdata = d;
        @(negedge mclk);
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
    endtask

    // idle cycle after each read so the data is sampled before the next read lands
    task automatic rd(input bmu_acc_t s, input logic [15:0] a, input logic [2:0] b,
        input logic [15:0] want);
        exp_q.push_back(want);
        acc(1'b0, s, a, b, 8'h00);
        @(negedge mclk);
    endtask

    task automatic mult(input logic [7:0] a, input logic [7:0] b, input logic bw);
        int t0;
        logic [15:0] p;
        p = 16'(a) * 16'(b);
        if (bw) begin
            for (int i = 0; i < 8; i++) begin
                acc(1'b1, BMU_ACC_BIT, OPA, i[2:0], {7'h00, a[i]});
            end
        end else begin
            acc(1'b1, BMU_ACC_BYTE, OPA, 3'h0, a);
        end
        if (bw) begin
            for (int i = 0; i < 8; i++) begin
                acc(1'b1, BMU_ACC_BIT, OPB, i[2:0], {7'h00, b[i]});
            end
        end else begin
            acc(1'b1, BMU_ACC_BYTE, OPB, 3'h0, b);
        end
        acc(1'b1, bw ? BMU_ACC_BIT : BMU_ACC_BYTE, CTL, 3'h0, 8'h01);
        t0 = cyc;
        rd(BMU_ACC_BYTE, CTL, 3'h0, 16'h0001);
        while (cyc < t0 + 16) @(negedge mclk);
        // stop lands on the 17th edge after the start edge
        acc(1'b1, BMU_ACC_BYTE, CTL, 3'h0, 8'h00);
        rd(BMU_ACC_WORD, RLO, 3'h0, p);
        rd(BMU_ACC_BYTE, RHI, 3'h0, {8'h00, p[15:8]});
        rd(BMU_ACC_BYTE, RLO, 3'h0, {8'h00, p[7:0]});
        rd(BMU_ACC_BIT, CTL, 3'h0, 16'h0000);
        rd(BMU_ACC_WORD, RLO, 3'h0, p);
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        rd_d1 <= cpu_rd;
        rd_d2 <= rd_d1;
    end

    always @(negedge mclk) begin
        if (rd_d2 && exp_q.size() > 0) begin
            cmp_rd(cpu_rdata, exp_q.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        $display("mismatch at %0t: run did not finish", $time);
        results();
    end

    initial begin
        logic [31:0] r;
        repeat (20) @(negedge mclk);
        rst_b = 1'b1;
        rd(BMU_ACC_BYTE, CTL, 3'h0, 16'h0000);
        rd(BMU_ACC_WORD, CTL, 3'h0, 16'h0000);
        rd(BMU_ACC_BYTE, 16'h0040, 3'h0, 16'h0000);
        mult(8'haa, 8'hd3, 1'b0);
        acc(1'b1, BMU_ACC_BYTE, RLO, 3'h0, 8'h55);
        acc(1'b1, BMU_ACC_WORD, OPA, 3'h0, 8'h33);
        rd(BMU_ACC_WORD, RLO, 3'h0, 16'h8c1e);
        rd(BMU_ACC_BYTE, OPA, 3'h0, 16'h00aa);
        rd(BMU_ACC_BIT, OPB, 3'h7, 16'h0001);
        acc(1'b1, BMU_ACC_BIT, CTL, 3'h3, 8'h01);
        rd(BMU_ACC_BYTE, CTL, 3'h0, 16'h0000);
        mult(8'hff, 8'hff, 1'b1);
        mult(8'h00, 8'h5a, 1'b0);
        mult(8'h01, 8'h80, 1'b1);
        // abandon a run after three of its eight steps; the next run must start from a clean counter
        acc(1'b1, BMU_ACC_BYTE, CTL, 3'h0, 8'h01);
        repeat (5) @(negedge mclk);
        acc(1'b1, BMU_ACC_BYTE, CTL, 3'h0, 8'h00);
        rd(BMU_ACC_BYTE, CTL, 3'h0, 16'h0000);
        mult(8'h9c, 8'h37, 1'b0);
        for (int i = 0; i < 6; i++) begin
            r = $random(seed);
            mult(r[7:0], r[15:8], r[16]);
        end
        acc(1'b1, BMU_ACC_BYTE, CTL, 3'h0, 8'h01);
        repeat (3) @(negedge mclk);
        rst_b = 1'b0;
        repeat (2) @(negedge mclk);
        rst_b = 1'b1;
        rd(BMU_ACC_BIT, CTL, 3'h0, 16'h0000);
        rd(BMU_ACC_BYTE, CTL, 3'h0, 16'h0000);
        repeat (4) @(negedge mclk);
        results();
    end
endmodule // byte_multiplier_unit_bench
